// ==== rtl/cdg_pkg.sv ====
// Package for the codec configuration block: control register layout,
// reset values, host port modes, serial word format and carrier structs.
// Assumes a single clock that also serves as the codec master clock.
package cdg_pkg;

  // ==========================================================================
  // Control registers
  localparam int          NUM_REGS    = 6;
  localparam int          REG_W       = 8;
  localparam logic [2:0]  REG_CTRL1   = 3'h1;
  localparam logic [2:0]  REG_CTRL2   = 3'h2;
  localparam logic [2:0]  REG_CTRL3   = 3'h3;
  localparam logic [2:0]  REG_CTRL4   = 3'h4;
  localparam logic [2:0]  REG_CTRL6   = 3'h6;

  // Control register 1
  localparam int          C1_FMT15P1  = 0;
  localparam int          C1_PROGMODE = 1;
  localparam int          C1_IIR      = 2;
  localparam int          C1_ALOOP    = 3;
  localparam int          C1_DLOOP    = 4;
  localparam int          C1_BYPASS   = 5;
  localparam int          C1_ADCOVF   = 6;
  localparam int          C1_DACOVF   = 7;
  // Control register 2
  localparam int          C2_GPI      = 0;
  localparam int          C2_GPO      = 1;
  localparam int          C2_HPC_LO   = 2;
  localparam int          C2_TURBO    = 4;
  localparam int          C2_BASE_LO  = 5;
  // Control register 3
  localparam int          C3_OSR512   = 0;
  localparam int          C3_ASYNC_LO = 1;
  localparam int          C3_ADCPD    = 4;
  localparam int          C3_DACPD    = 5;
  localparam int          C3_SWRESET  = 7;
  // Control register 4
  localparam int          C4_P_LO     = 0;
  localparam int          C4_M_LO     = 3;

  localparam logic [7:0]  RST_CTRL1   = 8'h00;
  localparam logic [7:0]  RST_CTRL2   = 8'h00;
  localparam logic [7:0]  RST_CTRL3   = 8'h00;
  localparam logic [7:0]  RST_CTRL4   = 8'h09;
  localparam logic [7:0]  RST_CTRL5   = 8'h00;
  localparam logic [7:0]  RST_CTRL6   = 8'h00;

  // Host port control field values
  localparam logic [1:0]  HPC_TWO_WIRE = 2'h0;
  localparam logic [1:0]  HPC_ALT_TWO  = 2'h1;
  localparam logic [1:0]  HPC_GPIO     = 2'h2;

  // ==========================================================================
  // Serial audio bus
  localparam int          WORD_BITS   = 16;
  localparam int          CW_READ     = 15;
  localparam int          CW_IDX_LO   = 12;
  localparam logic [9:0]  SCLK_MIN_PERIOD = 10'h002;
  localparam logic [3:0]  P_ZERO_MEANS = 4'h8;
  localparam logic [5:0]  M_ZERO_MEANS = 6'h20;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       read;
    logic [6:0] addr;
    logic [2:0] idx;
    logic [7:0] data;
  } cdg_host_req_s;

  typedef struct packed {
    logic       filterIir;
    logic       filterBypass;
    logic       analogLoop;
    logic       digitalLoop;
    logic       adcPowerDown;
    logic       dacPowerDown;
    logic       osr512;
    logic [2:0] asyncFactor;
  } cdg_path_ctl_s;

  typedef enum logic [1:0] {
    FR_WAIT = 2'b01,
    FR_RUN  = 2'b10
  } cdg_frame_e;

endpackage : cdg_pkg

// ==== rtl/cdg_sclk_div.sv ====
// Serial clock divider: a square wave of a programmable period in
// master clock cycles, plus a one-cycle pulse at each rising edge.
// Assumes period is at least two.
`timescale 1ns/1ps
module cdg_sclk_div
  import cdg_pkg::*;
#(
  parameter int W = 10
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] period,
  output logic              sclk,
  output logic              bitTick
);

  logic [W-1:0] count_r;

  // ==========================================================================
  // Counter and outputs
  always_ff @(posedge clock) begin
    if (rst || count_r >= period - W'(1)) begin
      count_r <= '0;
    end else begin
      count_r <= count_r + W'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sclk    <= 1'b0;
      bitTick <= 1'b0;
    end else begin
      sclk    <= (count_r < (period >> 1));
      bitTick <= (count_r == '0);
    end
  end

endmodule : cdg_sclk_div

// ==== rtl/cdg_frame_ser.sv ====
// Serial audio frame engine: 16-bit slots, MSB first, audio in slot 0
// and, when the control slot is enabled, control words in ctrlSlot.
// Assumes bitTick pulses once per serial clock period.
`timescale 1ns/1ps
module cdg_frame_ser
  import cdg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        bitTick,
  input  wire logic [4:0]  slots,
  input  wire logic [4:0]  ctrlSlot,
  input  wire logic        ctrlEn,
  input  wire logic [15:0] audioTx,
  input  wire logic [15:0] ctrlTx,
  input  wire logic        sdIn,
  output logic             sdOut,
  output logic             fsync,
  output logic             frameStart,
  output logic [15:0]      audioRx,
  output logic             audioRxValid,
  output logic [15:0]      ctrlRx,
  output logic             ctrlRxValid
);

  cdg_frame_e  state_r;
  logic [3:0]  bitIdx_r;
  logic [4:0]  slotIdx_r;
  logic [15:0] txShift_r;
  logic [15:0] rxShift_r;
  logic [15:0] loadWord;
  logic [15:0] rxWord;
  logic        lastBit;

  always_comb begin
    loadWord = 16'h0000;
    if (slotIdx_r == 5'h00) begin
      loadWord = audioTx;
    end else if (ctrlEn && slotIdx_r == ctrlSlot) begin
      loadWord = ctrlTx;
    end
    rxWord  = {rxShift_r[14:0], sdIn};
    lastBit = (bitIdx_r == 4'(WORD_BITS - 1));
  end

  // ==========================================================================
  // Slot and bit position
  always_ff @(posedge clock) begin
    if (rst) begin
      state_r   <= FR_WAIT;
      bitIdx_r  <= 4'h0;
      slotIdx_r <= 5'h00;
    end else if (bitTick) begin
      case (state_r)
        FR_WAIT: begin
          state_r <= FR_RUN;
        end
        FR_RUN: begin
          bitIdx_r <= bitIdx_r + 4'h1;
          if (lastBit) begin
            slotIdx_r <= (slotIdx_r >= slots - 5'h01) ? 5'h00 : slotIdx_r + 5'h01;
          end
        end
        default: begin
          state_r <= FR_WAIT;
        end
      endcase
    end
  end

  // ==========================================================================
  // Shifting
  always_ff @(posedge clock) begin
    if (rst) begin
      sdOut     <= 1'b0;
      fsync     <= 1'b0;
      txShift_r <= 16'h0000;
      rxShift_r <= 16'h0000;
    end else if (bitTick && state_r == FR_RUN) begin
      fsync     <= (bitIdx_r == 4'h0) && (slotIdx_r == 5'h00);
      rxShift_r <= rxWord;
      if (bitIdx_r == 4'h0) begin
        sdOut     <= loadWord[15];
        txShift_r <= {loadWord[14:0], 1'b0};
      end else begin
        sdOut     <= txShift_r[15];
        txShift_r <= {txShift_r[14:0], 1'b0};
      end
    end else if (bitTick) begin
      fsync <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      frameStart   <= 1'b0;
      audioRx      <= 16'h0000;
      audioRxValid <= 1'b0;
      ctrlRx       <= 16'h0000;
      ctrlRxValid  <= 1'b0;
    end else begin
      frameStart   <= bitTick && state_r == FR_RUN && bitIdx_r == 4'h0 && slotIdx_r == 5'h00;
      audioRxValid <= 1'b0;
      ctrlRxValid  <= 1'b0;
      if (bitTick && state_r == FR_RUN && lastBit) begin
        if (slotIdx_r == 5'h00) begin
          audioRx      <= rxWord;
          audioRxValid <= 1'b1;
        end else if (ctrlEn && slotIdx_r == ctrlSlot) begin
          ctrlRx      <= rxWord;
          ctrlRxValid <= 1'b1;
        end
      end
    end
  end

endmodule : cdg_frame_ser

// ==== rtl/cdg_codec_cfg.sv ====
// Codec control and serial interface core: six control registers, host
// port request handling, serial audio framing and path controls.
// Assumes host requests arrive already decoded from the two-wire bus and
// that the clock input is the codec master clock.
//
// Behaviour
// R01: Continuous mode carries only audio words
// R02: Programming mode adds control words to audio
// R03: Flag-format word with LSB one enters programming
// R04: Config bit picks FIR or IIR filter
// R05: Analog and digital loopback switch independently
// R06: Serial clock from sample rate or turbo divider
// R07: Host port field picks two-wire or alternate
// R08: General-purpose mode: data out, clock in
// R09: General-purpose output drives its held level
// R10: Bypass routes samples around selected filters
// R11: Address is base field then cascade position
// R12: Host selects cascade target; standalone is zero
// R13: Host keeps M even or multiple-of-four
// R14: Oversampling and async factor share one register
// R15: Separate ADC and DAC power-down controls
// R16: ADC and DAC overflow flags in register one
// R17: Software reset bit restores register defaults
// R18: Host may hardware reset through a GPIO
// R19: Six registers, each read and written alone
// R20: Accepted register writes are acknowledged
// R21: Writes take effect at frame boundary
`timescale 1ns/1ps
module cdg_codec_cfg
  import cdg_pkg::*;
#(
  parameter int NUM_DEV = 1
) (
  input  wire logic          clock,
  input  wire logic          rst,
  input  wire logic          hostReqValid,
  input  wire cdg_host_req_s hostReq,
  output logic               hostAck,
  output logic [7:0]         hostRdData,
  input  wire logic [3:0]    cascadePos,
  output logic [1:0]         hostPortMode,
  input  wire logic          sclIn,
  output logic               sdaOut,
  output logic               sdaOe,
  input  wire logic          adcOverflow,
  input  wire logic          dacOverflow,
  input  wire logic [15:0]   adcSample,
  output logic [15:0]        dacSample,
  output logic               dacSampleValid,
  input  wire logic          sdIn,
  output logic               sdOut,
  output logic               sclkOut,
  output logic               fsyncOut,
  output cdg_path_ctl_s      pathCtl
);

  logic [7:0]    cfg_r [1:NUM_REGS];
  logic [1:0]    ovf_r;
  logic          gpi_r;
  logic          progReq_r;
  logic          hostPend_r;
  logic [2:0]    hostPendIdx_r;
  logic [7:0]    hostPendData_r;
  logic          serPend_r;
  logic [2:0]    serPendIdx_r;
  logic [7:0]    serPendData_r;
  logic [15:0]   ctrlTx_r;
  logic [6:0]    devAddr;
  logic          hostTake;
  logic          progActive;
  logic [1:0]    hpc;
  logic          swReset;
  logic          hostApply;
  logic          serApply;
  logic [7:0]    ovfClr;
  logic [3:0]    pVal;
  logic [5:0]    mVal;
  logic [9:0]    sclkPeriod;
  logic [9:0]    baseDiv;
  logic [4:0]    slots;
  logic          bitTick;
  logic          frameStart;
  logic [15:0]   audioRx;
  logic          audioRxValid;
  logic [15:0]   ctrlRx;
  logic          ctrlRxValid;
  logic [15:0]   audioTx;
  logic          serSclk;
  logic          serSdOut;
  logic          serFsync;

  function automatic logic [7:0] readReg(input logic [2:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx >= REG_CTRL1 && idx <= REG_CTRL6) begin
      v = cfg_r[idx];
    end
    if (idx == REG_CTRL1) begin
      v[C1_DACOVF] = ovf_r[1];                                    // [R16]
      v[C1_ADCOVF] = ovf_r[0];                                    // [R16]
    end
    if (idx == REG_CTRL2) begin
      v[C2_GPI] = gpi_r;                                          // [R08]
    end
    if (idx == REG_CTRL3) begin
      v[C3_SWRESET] = 1'b0;
    end
    return v;
  endfunction : readReg

  // ==========================================================================
  // Decoded controls
  always_comb begin
    hpc        = cfg_r[REG_CTRL2][C2_HPC_LO +: 2];                // [R07]
    devAddr    = {cfg_r[REG_CTRL2][C2_BASE_LO +: 3], cascadePos}; // [R11]
    progActive = cfg_r[REG_CTRL1][C1_PROGMODE] | progReq_r;       // [R02]
    hostApply  = frameStart && hostPend_r;                        // [R21]
    serApply   = frameStart && serPend_r;                         // [R21]
    swReset    = (hostApply && hostPendIdx_r == REG_CTRL3 && hostPendData_r[C3_SWRESET])
              || (serApply && serPendIdx_r == REG_CTRL3 && serPendData_r[C3_SWRESET]); // [R17]
    ovfClr = 8'h00;
    if (hostApply && hostPendIdx_r == REG_CTRL1) begin
      ovfClr = ovfClr | hostPendData_r;
    end
    if (serApply && serPendIdx_r == REG_CTRL1) begin
      ovfClr = ovfClr | serPendData_r;
    end
  end

  // Host request taken only outside pin mode, when addressed, mapped and, for a write, the write slot is free
  always_comb begin
    hostTake = hostReqValid
            && (hpc != HPC_GPIO)                                  // [R07]
            && (hostReq.addr == devAddr)                          // [R12]
            && (hostReq.idx >= REG_CTRL1) && (hostReq.idx <= REG_CTRL6) // [R19]
            && (hostReq.read || !hostPend_r);
  end

  // ==========================================================================
  // Host port answers
  always_ff @(posedge clock) begin
    if (rst) begin
      hostAck    <= 1'b0;
      hostRdData <= 8'h00;
    end else begin
      hostAck <= hostTake;                                        // [R20]
      if (hostTake && hostReq.read) begin
        hostRdData <= readReg(hostReq.idx);                       // [R19]
      end
    end
  end

  // Pending host write, applied at the next frame start
  always_ff @(posedge clock) begin
    if (rst) begin
      hostPend_r     <= 1'b0;
      hostPendIdx_r  <= 3'h0;
      hostPendData_r <= 8'h00;
    end else if (hostTake && !hostReq.read) begin
      hostPend_r     <= 1'b1;
      hostPendIdx_r  <= hostReq.idx;
      hostPendData_r <= hostReq.data;
    end else if (hostApply) begin
      hostPend_r <= 1'b0;                                         // [R21]
    end
  end

  // ==========================================================================
  // Control words on the serial bus
  always_ff @(posedge clock) begin
    if (rst) begin
      serPend_r     <= 1'b0;
      serPendIdx_r  <= 3'h0;
      serPendData_r <= 8'h00;
      ctrlTx_r      <= 16'h0000;
    end else begin
      if (ctrlRxValid && !ctrlRx[CW_READ]) begin
        serPend_r     <= 1'b1;                                    // [R02]
        serPendIdx_r  <= ctrlRx[CW_IDX_LO +: 3];
        serPendData_r <= ctrlRx[7:0];
      end else if (serApply) begin
        serPend_r <= 1'b0;
      end
      if (ctrlRxValid && ctrlRx[CW_READ]) begin
        ctrlTx_r <= {1'b1, ctrlRx[CW_IDX_LO +: 3], 4'h0, readReg(ctrlRx[CW_IDX_LO +: 3])};
      end
    end
  end

  // In-band request for programming mode, ended by the control word
  always_ff @(posedge clock) begin
    if (rst || swReset) begin
      progReq_r <= 1'b0;
    end else if (audioRxValid && cfg_r[REG_CTRL1][C1_FMT15P1]
                 && !progActive && audioRx[0]) begin
      progReq_r <= 1'b1;                                          // [R03]
    end else if (ctrlRxValid) begin
      progReq_r <= 1'b0;                                          // [R01]
    end
  end

  // ==========================================================================
  // Control registers
  for (genvar g = 1; g <= NUM_REGS; g++) begin : gRegs
    localparam logic [7:0] RST_VAL = (g == 1) ? RST_CTRL1 : (g == 2) ? RST_CTRL2 :
                                     (g == 3) ? RST_CTRL3 : (g == 4) ? RST_CTRL4 :
                                     (g == 5) ? RST_CTRL5 : RST_CTRL6;
    always_ff @(posedge clock) begin
      if (rst || swReset) begin
        cfg_r[g] <= RST_VAL;                                      // [R17]
      end else if (serApply && serPendIdx_r == 3'(g)) begin
        cfg_r[g] <= serPendData_r;                                // [R19] [R21]
      end else if (hostApply && hostPendIdx_r == 3'(g)) begin
        cfg_r[g] <= hostPendData_r;                               // [R19] [R21]
      end
    end
  end

  // Overflow flags: a new event wins over a clear in the same cycle
  always_ff @(posedge clock) begin
    if (rst || swReset) begin
      ovf_r <= 2'b00;
    end else begin
      ovf_r[0] <= (ovf_r[0] & ~ovfClr[C1_ADCOVF]) | adcOverflow;  // [R16]
      ovf_r[1] <= (ovf_r[1] & ~ovfClr[C1_DACOVF]) | dacOverflow;  // [R16]
    end
  end

  // ==========================================================================
  // Host port pins
  always_ff @(posedge clock) begin
    if (rst) begin
      gpi_r        <= 1'b0;
      sdaOut       <= 1'b0;
      sdaOe        <= 1'b0;
      hostPortMode <= HPC_TWO_WIRE;
    end else begin
      gpi_r        <= sclIn;                                      // [R08]
      sdaOe        <= (hpc == HPC_GPIO);                          // [R08]
      sdaOut       <= cfg_r[REG_CTRL2][C2_GPO];                   // [R09]
      hostPortMode <= hpc;                                        // [R07]
    end
  end

  // ==========================================================================
  // Serial clock rate
  always_comb begin
    pVal = (cfg_r[REG_CTRL4][C4_P_LO +: 3] == 3'h0) ? P_ZERO_MEANS
         : {1'b0, cfg_r[REG_CTRL4][C4_P_LO +: 3]};
    mVal = (cfg_r[REG_CTRL4][C4_M_LO +: 5] == 5'h00) ? M_ZERO_MEANS
         : {1'b0, cfg_r[REG_CTRL4][C4_M_LO +: 5]};
    baseDiv = 10'((pVal * mVal) / NUM_DEV) >> progActive;         // [R06]
    if (cfg_r[REG_CTRL2][C2_TURBO]) begin
      sclkPeriod = {6'h00, pVal};                                 // [R06]
    end else begin
      sclkPeriod = baseDiv;                                       // [R06]
    end
    if (sclkPeriod < SCLK_MIN_PERIOD) begin
      sclkPeriod = SCLK_MIN_PERIOD;
    end
    slots = 5'(NUM_DEV) << progActive;                            // [R01] [R02]
  end

  cdg_sclk_div #(
    .W       (10)
  ) uSclkDiv (
    .clock   (clock),
    .rst     (rst),
    .period  (sclkPeriod),
    .sclk    (serSclk),
    .bitTick (bitTick)
  );

  // ==========================================================================
  // Audio paths
  always_comb begin
    audioTx = adcSample;
    if (cfg_r[REG_CTRL1][C1_DLOOP]) begin
      audioTx = audioRx;                                          // [R05]
    end
    if (cfg_r[REG_CTRL3][C3_ADCPD]) begin
      audioTx = 16'h0000;                                         // [R15]
    end
    if (cfg_r[REG_CTRL1][C1_FMT15P1]) begin
      audioTx[0] = 1'b0;                                          // [R03]
    end
  end

  cdg_frame_ser uFrame (
    .clock        (clock),
    .rst          (rst),
    .bitTick      (bitTick),
    .slots        (slots),
    .ctrlSlot     (5'(NUM_DEV)),
    .ctrlEn       (progActive),                                   // [R01] [R02]
    .audioTx      (audioTx),
    .ctrlTx       (ctrlTx_r),
    .sdIn         (sdIn),
    .sdOut        (serSdOut),
    .fsync        (serFsync),
    .frameStart   (frameStart),
    .audioRx      (audioRx),
    .audioRxValid (audioRxValid),
    .ctrlRx       (ctrlRx),
    .ctrlRxValid  (ctrlRxValid)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      sclkOut        <= 1'b0;
      sdOut          <= 1'b0;
      fsyncOut       <= 1'b0;
      dacSample      <= 16'h0000;
      dacSampleValid <= 1'b0;
    end else begin
      sclkOut        <= serSclk;
      sdOut          <= serSdOut;
      fsyncOut       <= serFsync;
      dacSampleValid <= audioRxValid;
      if (audioRxValid) begin
        if (cfg_r[REG_CTRL3][C3_DACPD]) begin
          dacSample <= 16'h0000;                                  // [R15]
        end else if (cfg_r[REG_CTRL1][C1_FMT15P1]) begin
          dacSample <= {audioRx[15:1], 1'b0};                     // [R03]
        end else begin
          dacSample <= audioRx;
        end
      end
    end
  end

  // ==========================================================================
  // Path controls
  always_ff @(posedge clock) begin
    if (rst) begin
      pathCtl <= '0;
    end else begin
      pathCtl.filterIir    <= cfg_r[REG_CTRL1][C1_IIR];            // [R04]
      pathCtl.filterBypass <= cfg_r[REG_CTRL1][C1_BYPASS];         // [R10]
      pathCtl.analogLoop   <= cfg_r[REG_CTRL1][C1_ALOOP];          // [R05]
      pathCtl.digitalLoop  <= cfg_r[REG_CTRL1][C1_DLOOP];          // [R05]
      pathCtl.adcPowerDown <= cfg_r[REG_CTRL3][C3_ADCPD];          // [R15]
      pathCtl.dacPowerDown <= cfg_r[REG_CTRL3][C3_DACPD];          // [R15]
      pathCtl.osr512       <= cfg_r[REG_CTRL3][C3_OSR512];         // [R14]
      pathCtl.asyncFactor  <= cfg_r[REG_CTRL3][C3_ASYNC_LO +: 3];  // [R14]
    end
  end

endmodule : cdg_codec_cfg

// ==== verif/cdg_codec_cfg_asserts.sv ====
// Checker: host port and pin relations of the codec core.
// Assumes a bind to cdg_codec_cfg; ack shows one cycle after the take.
`timescale 1ns/1ps
module cdg_codec_cfg_asserts
  import cdg_pkg::*;
(
  input wire logic          clock,
  input wire logic          rst,
  input wire logic          hostReqValid,
  input wire cdg_host_req_s hostReq,
  input wire logic          hostAck,
  input wire logic [7:0]    hostRdData,
  input wire logic [3:0]    cascadePos,
  input wire logic [1:0]    hostPortMode,
  input wire logic          sdaOe,
  input wire logic          dacSampleValid
);
  // ==========================================================
  // Host port and pins
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_gpio_held; (hostPortMode == HPC_GPIO) [*2]; endsequence
  sequence s_ack_pulse; hostAck ##1 !hostAck; endsequence
  a_ack_pulse: assert property ($rose(hostAck) |-> s_ack_pulse)
    else $error("ack wider than one cycle");
  a_ack_cause: assert property (hostAck |-> $past(hostReqValid))
    else $error("ack without request");
  a_gpio_noack: assert property (s_gpio_held |-> !hostAck)
    else $error("ack in pin mode");
  a_ack_pos: assert property (hostAck |-> $past(hostReq.addr[3:0]) == $past(cascadePos))
    else $error("ack for other position");
  a_ack_idx: assert property (hostAck |-> $past(hostReq.idx) inside {[3'h1:3'h6]})
    else $error("ack for bad index");
  a_oe_mode: assert property (sdaOe == (hostPortMode == HPC_GPIO))
    else $error("data pin enable wrong");
  a_rd_hold: assert property (!$stable(hostRdData) |-> hostAck && $past(hostReq.read))
    else $error("read data moved");
  a_dac_pulse: assert property (dacSampleValid |=> !dacSampleValid)
    else $error("sample strobe too wide");
endmodule : cdg_codec_cfg_asserts

// ==== verif/cdg_dsp_model.sv ====
// Serial audio peer: one audio word per frame, MSB first.
// Assumes fsyncOut marks frames and sclkOut falls between bits.
`timescale 1ns/1ps
module cdg_dsp_model
  import cdg_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclkOut,
  input  wire logic        fsyncOut,
  input  wire logic [15:0] txWord,
  output logic             sdIn
);
  logic       sclkD_r;
  logic [4:0] bitIdx_r;
  // ==========================================================
  // Word shifter, flag bit kept clear so no control is requested
  always_ff @(posedge clock) begin
    sclkD_r <= sclkOut;
    if (rst) begin
      bitIdx_r <= 5'h10;
      sdIn     <= 1'b0;
    end else if (sclkD_r && !sclkOut) begin
      if (fsyncOut) begin
        bitIdx_r <= 5'h01;
        sdIn     <= txWord[15];
      end else if (bitIdx_r < 5'h10) begin
        bitIdx_r <= bitIdx_r + 5'h01;
        sdIn     <= txWord[4'hf - bitIdx_r[3:0]];
      end else begin
        sdIn     <= !sdIn;
      end
    end
  end
endmodule : cdg_dsp_model

// ==== verif/tb_top.sv ====
// Testbench for the codec core: host port, path controls, pins.
// Assumes default base address, one codec and serial peer model.
`timescale 1ns/1ps
module tb_top
  import cdg_pkg::*;
;
  logic clock, rst, hostReqValid, hostAck, sclIn, sdaOut, sdaOe, ok;
  logic adcOverflow, dacOverflow, sdIn, sdOut, sclkOut, fsyncOut, dacSampleValid;
  logic [15:0]   adcSample, dacSample;
  logic [7:0]    hostRdData;
  logic [6:0]    addr;
  logic [3:0]    cascadePos;
  logic [1:0]    hostPortMode;
  cdg_host_req_s hostReq;
  cdg_path_ctl_s pathCtl;
  int            fail_count, cmp_count, n;
  cdg_codec_cfg dut_u (.clock, .rst, .hostReqValid, .hostReq, .hostAck, .hostRdData,
    .cascadePos, .hostPortMode, .sclIn, .sdaOut, .sdaOe, .adcOverflow, .dacOverflow,
    .adcSample, .dacSample, .dacSampleValid, .sdIn, .sdOut, .sclkOut, .fsyncOut, .pathCtl);
  cdg_dsp_model dsp_u (.clock, .rst, .sclkOut, .fsyncOut, .txWord(16'h1234), .sdIn);
  // ==========================================================
  // Helpers
  task automatic check(input string name, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic host(input logic rd, input logic [2:0] idx, input logic [7:0] d);
    @(negedge clock);
    hostReq = '{read: rd, addr: addr, idx: idx, data: d};
    hostReqValid = 1'b1;
    ok = 1'b0;
    for (int i = 0; i < 6 && !ok; i++) begin
      @(negedge clock);
      ok = hostAck;
    end
    hostReqValid = 1'b0;
  endtask : host
  task automatic wr(input logic [2:0] idx, input logic [7:0] d);
    host(1'b0, idx, d);
    check("write ack", ok, 1'b1);
    repeat (80) @(negedge clock);
  endtask : wr
  task automatic rd(input logic [2:0] idx, input logic [7:0] exp);
    host(1'b1, idx, 8'h00);
    check("read ack", ok, 1'b1);
    check("read data", hostRdData, exp);
  endtask : rd
  task automatic final_report;
    if (fail_count == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  // ==========================================================
  // Scenarios
  task automatic t_path;
    for (int i = 1; i <= 6; i++) rd(3'(i), (i == 4) ? RST_CTRL4 : 8'h00);
    check("oe", sdaOe, 1'b0);
    wr(3'h1, 8'h3c);
    check("iir", pathCtl.filterIir, 1'b1);
    check("bypass", pathCtl.filterBypass, 1'b1);
    wr(3'h1, 8'h08);
    check("loops", {pathCtl.analogLoop, pathCtl.digitalLoop}, 2'b10);
    check("fir", pathCtl.filterIir, 1'b0);
    adcOverflow = 1'b1;
    @(negedge clock);
    adcOverflow = 1'b0;
    rd(3'h1, 8'h48);
    dacOverflow = 1'b1;
    @(negedge clock);
    dacOverflow = 1'b0;
    rd(3'h1, 8'hc8);
  endtask : t_path
  task automatic t_pwr;
    wr(3'h4, 8'h21);
    wr(3'h3, 8'h3b);
    check("osr async", {pathCtl.osr512, pathCtl.asyncFactor}, 4'hd);
    check("pd", {pathCtl.adcPowerDown, pathCtl.dacPowerDown}, 2'b11);
    for (n = 0; n < 200 && !dacSampleValid; n++) @(negedge clock);
    check("dac strobe", dacSampleValid, 1'b1);
    check("dac muted", dacSample, 16'h0000);
    @(negedge clock);
    for (n = 1; n < 200 && !dacSampleValid; n++) @(negedge clock);
    check("frame", n, 16'h0040);
    wr(3'h3, 8'h10);
    check("pd", {pathCtl.adcPowerDown, pathCtl.dacPowerDown}, 2'b10);
  endtask : t_pwr
  task automatic t_addr;
    addr = 7'h06;
    host(1'b1, 3'h1, 8'h00);
    check("foreign ack", ok, 1'b0);
    addr = 7'h05;
    host(1'b1, 3'h7, 8'h00);
    check("index ack", ok, 1'b0);
    wr(3'h2, 8'h20);
    addr = 7'h15;
    rd(3'h2, 8'h20);
    wr(3'h3, 8'h80);
    addr = 7'h05;
    rd(3'h2, 8'h00);
    rd(3'h1, 8'h00);
    check("path", pathCtl, 10'h000);
  endtask : t_addr
  task automatic t_gpio;
    sclIn = 1'b1;
    wr(3'h2, 8'h04);
    check("mode", hostPortMode, HPC_ALT_TWO);
    rd(3'h2, 8'h05);
    wr(3'h2, 8'h0a);
    check("mode", hostPortMode, HPC_GPIO);
    check("oe", sdaOe, 1'b1);
    check("gpo", sdaOut, 1'b1);
    host(1'b1, 3'h2, 8'h00);
    check("pin ack", ok, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    check("mode", hostPortMode, HPC_TWO_WIRE);
  endtask : t_gpio
  // ==========================================================
  // Clock, run and watchdog
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  initial begin
    {rst, hostReqValid, adcOverflow, dacOverflow, sclIn} = 5'h10;
    hostReq = '0;
    addr = 7'h05;
    cascadePos = 4'h5;
    adcSample = 16'h2468;
    fail_count = 0;
    cmp_count = 0;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_path;
    t_pwr;
    t_addr;
    t_gpio;
    final_report;
  end
  initial begin
    #2000000;
    fail_count++;
    final_report;
  end
endmodule : tb_top

bind cdg_codec_cfg cdg_codec_cfg_asserts chk_u (.clock, .rst, .hostReqValid, .hostReq,
  .hostAck, .hostRdData, .cascadePos, .hostPortMode, .sdaOe, .dacSampleValid);
